// ### common/ext_bus_pkg.sv
`default_nettype none
package ext_bus_pkg;
  // ===========================================================
  // register byte offsets
  localparam logic [7:0] RTCS_OFF  = 8'h00;
  localparam logic [7:0] RCNT_OFF  = 8'h04;
  localparam logic [7:0] RCOR_OFF  = 8'h08;
  localparam logic [7:0] SDC_OFF   = 8'h0c;
  localparam logic [7:0] AWC_OFF   = 8'h10;
  localparam logic [7:0] AADR_OFF  = 8'h14;
  localparam logic [7:0] AWDAT_OFF = 8'h18;
  localparam logic [7:0] ACMD_OFF  = 8'h1c;
  localparam logic [7:0] ASTAT_OFF = 8'h20;
  localparam logic [7:0] ARDAT_OFF = 8'h24;
  // ===========================================================
  // field positions
  localparam int CMF_BIT   = 7;
  localparam int CKS_LSB   = 3;
  localparam int RRC_LSB   = 0;
  localparam int RFEN_BIT  = 11;
  localparam int WRD_LSB   = 0;
  localparam int WWR_LSB   = 4;
  localparam int WM_BIT    = 8;
  localparam int SPLIT_BIT = 9;
  localparam int W16_BIT   = 10;
  localparam int CMD_WR    = 2;
  localparam logic [15:0] WR_KEY   = 16'ha55a;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  // ===========================================================
  // bus clock is aclk over two; refresh prescaler counts bus clocks
  localparam int BUS_DIV = 2;
  localparam int PRE_W   = 12;
  localparam logic [1:0] RESP_OK  = 2'b00;
  localparam logic [1:0] RESP_ERR = 2'b10;
  typedef enum logic [2:0] {
    ST_IDLE, ST_T1, ST_TW, ST_T2, ST_TNOP
  } bus_st_e;
endpackage : ext_bus_pkg
`default_nettype wire

// ### design/ext_bus_ctrl.sv
// Functional notes
// - match starts 1/2/4/6/8 back-to-back refreshes
// - 8-bit counter on selected clock, clears on match
// - counter wraps from 255 to zero
// - count/constant writes need key in top half
// - match sets flag and clears counter
// - enabled match raises refresh request until done
// - new match replaces any unserviced request
// - upper bits read zero, registers reset zero
// - endian caught from strap pin after reset
// - external width 8 or 16 bits
// - wide access split into narrow bus cycles
// - 16-bit big endian lanes and halfword order
// - 16-bit little endian lanes and halfword order
// - 8-bit: low lane, ascending byte order
// - no-wait access takes two bus clocks
// - start strobe low for one bus clock
// - reads fetch full width; writes strobe bytes
// - direction output high while idle
// - idle check cycle between beats unless masked
// - programmed wait cycles, optional read/write split
// - wait sampled at falling edge before T2
// - clock select stops or divides refresh counter clock
// - refresh enable gates refresh requests
// - flag clears by zero write after read
`default_nettype none
module ext_bus_ctrl
  import ext_bus_pkg::*;
#(
  parameter int ADDR_W = 26
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic [7:0]        s_awaddr,
  input  wire logic              s_awvalid,
  output logic                   s_awready,
  input  wire logic [31:0]       s_wdata,
  input  wire logic [3:0]        s_wstrb,
  input  wire logic              s_wvalid,
  output logic                   s_wready,
  output logic [1:0]             s_bresp,
  output logic                   s_bvalid,
  input  wire logic              s_bready,
  input  wire logic [7:0]        s_araddr,
  input  wire logic              s_arvalid,
  output logic                   s_arready,
  output logic [31:0]            s_rdata,
  output logic [1:0]             s_rresp,
  output logic                   s_rvalid,
  input  wire logic              s_rready,
  input  wire logic              endian_select_pin,
  input  wire logic              wait_n,
  input  wire logic              refresh_done,
  output logic                   refresh_req,
  output logic                   bus_clock_output,
  output logic [ADDR_W-1:0]      ext_addr,
  output logic [15:0]            ext_dout,
  input  wire logic [15:0]       ext_din,
  output logic                   ext_doe_n,
  output logic                   cs_n,
  output logic                   rd_n,
  output logic                   rd_wr,
  output logic [1:0]             byte_write_strobe_n,
  output logic                   bus_cycle_start_strobe_n
);
  // ===========================================================
  // register bus slave
  logic        aw_q, b_q, ar_q, r_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] rdata_q;
  wire         wr_go = s_awvalid & s_wvalid & aw_q;
  wire         rd_go = s_arvalid & ar_q;
  wire [31:0]  wmask = {{8{s_wstrb[3]}}, {8{s_wstrb[2]}},
                        {8{s_wstrb[1]}}, {8{s_wstrb[0]}}};
  wire         key_ok = (s_wdata[31:16] == WR_KEY) & (&s_wstrb[3:2]);
  wire wr_rtcs = wr_go & (s_awaddr == RTCS_OFF);
  wire wr_cnt  = wr_go & (s_awaddr == RCNT_OFF);
  wire wr_cor  = wr_go & (s_awaddr == RCOR_OFF);
  wire wr_sdc  = wr_go & (s_awaddr == SDC_OFF);
  wire wr_awc  = wr_go & (s_awaddr == AWC_OFF);
  wire wr_aadr = wr_go & (s_awaddr == AADR_OFF);
  wire wr_awd  = wr_go & (s_awaddr == AWDAT_OFF);
  wire wr_cmd  = wr_go & (s_awaddr == ACMD_OFF) & s_wstrb[0];
  wire wr_hit  = wr_rtcs | wr_cnt | wr_cor | wr_sdc | wr_awc | wr_aadr | wr_awd
                 | (wr_go & (s_awaddr == ACMD_OFF));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q    <= 1'b0;
      b_q     <= 1'b0;
      bresp_q <= RESP_OK;
    end else if (ce) begin
      aw_q <= s_awvalid & s_wvalid & ~aw_q & ~b_q;
      if (wr_go) begin
        b_q     <= 1'b1;
        bresp_q <= wr_hit ? RESP_OK : RESP_ERR;
      end else if (s_bready) begin
        b_q <= 1'b0;
      end
    end
  end

  // ===========================================================
  // refresh timer registers
  logic [7:0]  cnt_q, cor_q;
  logic        cmf_q, cmf_seen_q, rfen_q;
  logic [2:0]  cks_q, rrc_q;
  logic [3:0]  rrem_q;
  logic [PRE_W-1:0] pre_q;
  logic        ph_q;
  wire         tick = ph_q;
  wire [31:0]  rtcs_rd = {24'h0, cmf_q, 1'b0, cks_q, rrc_q};
  wire [31:0]  rtcs_new = (rtcs_rd & ~wmask) | (s_wdata & wmask);
  logic [PRE_W-1:0] div_m;
  always_comb begin
    case (cks_q)
      3'd1:    div_m = 12'h003;
      3'd2:    div_m = 12'h00f;
      3'd3:    div_m = 12'h03f;
      3'd4:    div_m = 12'h0ff;
      3'd5:    div_m = 12'h3ff;
      3'd6:    div_m = 12'h7ff;
      default: div_m = 12'hfff;
    endcase
  end
  wire inc   = tick & (cks_q != 3'd0) & ((pre_q & div_m) == div_m);
  wire match = inc & (cnt_q == cor_q);
  logic [3:0] burst_n;
  always_comb begin
    case (rrc_q)
      3'd1:    burst_n = 4'd2;
      3'd2:    burst_n = 4'd4;
      3'd3:    burst_n = 4'd6;
      3'd4:    burst_n = 4'd8;
      default: burst_n = 4'd1; // reserved codes fall back to one
    endcase
  end
  wire rd_rtcs = rd_go & (s_araddr == RTCS_OFF);
  wire cmf_clr = wr_rtcs & key_ok & cmf_seen_q & ~rtcs_new[CMF_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ph_q  <= 1'b0;
      pre_q <= '0;
    end else if (ce) begin
      ph_q <= ~ph_q;
      if (tick) pre_q <= pre_q + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= RST_ZERO[7:0];
      cor_q <= RST_ZERO[7:0];
    end else if (ce) begin
      if (wr_cnt && key_ok) cnt_q <= s_wdata[7:0];
      else if (match) cnt_q <= 8'h00;
      else if (inc) cnt_q <= cnt_q + 8'h01;
      if (wr_cor && key_ok) cor_q <= s_wdata[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmf_q      <= 1'b0;
      cmf_seen_q <= 1'b0;
      cks_q      <= RST_ZERO[2:0];
      rrc_q      <= RST_ZERO[2:0];
      rfen_q     <= 1'b0;
    end else if (ce) begin
      if (match) cmf_q <= 1'b1; // set beats a same-cycle clear
      else if (cmf_clr) cmf_q <= 1'b0;
      if (rd_rtcs) cmf_seen_q <= cmf_q;
      else if (cmf_clr) cmf_seen_q <= 1'b0;
      if (wr_rtcs && key_ok) begin
        cks_q <= rtcs_new[CKS_LSB +: 3];
        rrc_q <= rtcs_new[RRC_LSB +: 3];
      end
      if (wr_sdc && s_wstrb[1]) rfen_q <= s_wdata[RFEN_BIT];
    end
  end

  // refresh request stays until the sequencer has done the burst
  wire [3:0] rrem_d = !rfen_q ? 4'd0
                    : match ? burst_n
                    : (refresh_done && rrem_q != 4'd0) ? rrem_q - 4'd1 : rrem_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rrem_q      <= 4'd0;
      refresh_req <= 1'b0;
    end else if (ce) begin
      rrem_q      <= rrem_d;
      refresh_req <= |rrem_d;
    end
  end

  // ===========================================================
  // access configuration and strap
  logic [10:0] awc_q;
  logic [ADDR_W-1:0] aadr_q;
  logic [31:0] awd_q, ard_q;
  logic        little_q, strap_q;
  logic [1:0]  size_q;
  logic        wr_q, pend_q;
  wire         w16 = awc_q[W16_BIT];
  wire         wm  = awc_q[WM_BIT];
  wire [3:0]   wset = (wr_q && awc_q[SPLIT_BIT]) ? awc_q[WWR_LSB +: 4]
                                                 : awc_q[WRD_LSB +: 4];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_q  <= 1'b0;
      little_q <= 1'b0;
    end else if (ce && !strap_q) begin
      strap_q  <= 1'b1;
      little_q <= endian_select_pin;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awc_q  <= RST_ZERO[10:0];
      aadr_q <= '0;
      awd_q  <= RST_ZERO;
    end else if (ce) begin
      if (wr_awc) awc_q <= 11'((s_wdata & wmask) | ({21'h0, awc_q} & ~wmask));
      if (wr_aadr) aadr_q <= ADDR_W'(s_wdata);
      if (wr_awd) awd_q <= (awd_q & ~wmask) | (s_wdata & wmask);
    end
  end

  // ===========================================================
  // beat datapath
  bus_st_e     st_q;
  logic [1:0]  beat_q;
  logic [3:0]  wcnt_q;
  logic        wseen_q;
  wire [2:0]   nbeats = w16 ? ((size_q == 2'd2) ? 3'd2 : 3'd1)
                            : (3'd1 << size_q);
  wire         last = ({1'b0, beat_q} == nbeats - 3'd1);
  // idle starts from beat zero, whatever the last command left behind
  wire [1:0]   nb_sel = (st_q == ST_IDLE) ? 2'd0
                      : (st_q == ST_T2) ? beat_q + 2'd1 : beat_q;
  // element index walks down for big endian, up for little
  wire [1:0]   el_d = little_q ? nb_sel : 2'(nbeats - 3'd1 - {1'b0, nb_sel});
  wire [1:0]   el_r = little_q ? beat_q : 2'(nbeats - 3'd1 - {1'b0, beat_q});
  wire [4:0]   sh_d = w16 ? {el_d[0], 4'h0} : {el_d, 3'h0};
  wire [4:0]   sh_r = w16 ? {el_r[0], 4'h0} : {el_r, 3'h0};
  wire [31:0]  wsh = awd_q >> sh_d;
  wire [ADDR_W-1:0] badr = aadr_q + (w16 ? ADDR_W'({nb_sel, 1'b0})
                                         : ADDR_W'(nb_sel));
  wire         up = w16 & (size_q == 2'd0) & (aadr_q[0] == little_q);
  wire [15:0]  dlane = !w16 ? {8'h00, wsh[7:0]}
                     : (size_q != 2'd0) ? wsh[15:0]
                     : up ? {wsh[7:0], 8'h00} : {8'h00, wsh[7:0]};
  wire [1:0]   strb_n = !w16 ? 2'b10 : (size_q != 2'd0) ? 2'b00
                      : up ? 2'b01 : 2'b10;
  wire [15:0]  rpiece = !w16 ? {8'h00, ext_din[7:0]}
                      : (size_q != 2'd0) ? ext_din
                      : up ? {8'h00, ext_din[15:8]} : {8'h00, ext_din[7:0]};
  wire         samp = ~ph_q & ~wm & (wcnt_q == 4'd0)
                      & ((st_q == ST_T1) || (st_q == ST_TW));

  // ===========================================================
  // bus cycle sequencer, advances once per bus clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_q <= 1'b0;
      size_q <= 2'd0;
      wr_q   <= 1'b0;
    end else if (ce) begin
      if (wr_cmd && !pend_q && st_q == ST_IDLE) begin
        pend_q <= 1'b1;
        size_q <= (s_wdata[1:0] == 2'd3) ? 2'd2 : s_wdata[1:0];
        wr_q   <= s_wdata[CMD_WR];
      end else if (tick && st_q == ST_IDLE) begin
        pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wseen_q <= 1'b0;
    end else if (ce && !ph_q) begin
      wseen_q <= samp & ~wait_n;
    end
  end

  wire start_beat = tick & (((st_q == ST_IDLE) & pend_q) | (st_q == ST_TNOP)
                    | ((st_q == ST_T2) & ~last & wm));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q   <= ST_IDLE;
      beat_q <= 2'd0;
      wcnt_q <= 4'd0;
      ard_q  <= RST_ZERO;
    end else if (ce && tick) begin
      case (st_q)
        ST_IDLE: if (pend_q) begin
          st_q   <= ST_T1;
          beat_q <= 2'd0;
          wcnt_q <= wset;
          if (!wr_q) ard_q <= RST_ZERO;
        end
        ST_T1, ST_TW: begin
          if (wcnt_q != 4'd0) begin
            st_q   <= ST_TW;
            wcnt_q <= wcnt_q - 4'd1;
          end else if (wseen_q) st_q <= ST_TW;
          else st_q <= ST_T2;
        end
        ST_T2: begin
          if (!wr_q) ard_q <= ard_q | ({16'h0, rpiece} << sh_r);
          beat_q <= beat_q + 2'd1;
          wcnt_q <= wset;
          if (last) st_q <= ST_IDLE;
          else if (!wm) st_q <= ST_TNOP;
          else st_q <= ST_T1;
        end
        ST_TNOP: st_q <= ST_T1;
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // ===========================================================
  // external pins, all registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_clock_output         <= 1'b0;
      ext_addr                 <= '0;
      ext_dout                 <= 16'h0000;
      ext_doe_n                <= 1'b1;
      cs_n                     <= 1'b1;
      rd_n                     <= 1'b1;
      rd_wr                    <= 1'b1;
      byte_write_strobe_n      <= 2'b11;
      bus_cycle_start_strobe_n <= 1'b1;
    end else if (ce) begin
      bus_clock_output <= ph_q;
      if (start_beat) begin
        ext_addr                 <= badr;
        ext_dout                 <= dlane;
        ext_doe_n                <= ~wr_q;
        cs_n                     <= 1'b0;
        rd_n                     <= wr_q;
        rd_wr                    <= ~wr_q;
        byte_write_strobe_n      <= wr_q ? strb_n : 2'b11;
        bus_cycle_start_strobe_n <= 1'b0;
      end else if (tick) begin
        bus_cycle_start_strobe_n <= 1'b1;
        if (st_q == ST_T2) begin
          ext_doe_n           <= 1'b1;
          cs_n                <= 1'b1;
          rd_n                <= 1'b1;
          rd_wr               <= 1'b1;
          byte_write_strobe_n <= 2'b11;
        end
      end
    end
  end

  // ===========================================================
  // read side of the register bus
  wire [31:0] stat = {29'h0, little_q, pend_q, (st_q != ST_IDLE) | pend_q};
  wire [31:0] rmux = (s_araddr == RTCS_OFF)  ? rtcs_rd
                   : (s_araddr == RCNT_OFF)  ? {24'h0, cnt_q}
                   : (s_araddr == RCOR_OFF)  ? {24'h0, cor_q}
                   : (s_araddr == SDC_OFF)   ? {20'h0, rfen_q, 11'h0}
                   : (s_araddr == AWC_OFF)   ? {21'h0, awc_q}
                   : (s_araddr == AADR_OFF)  ? 32'(aadr_q)
                   : (s_araddr == AWDAT_OFF) ? awd_q
                   : (s_araddr == ASTAT_OFF) ? stat
                   : (s_araddr == ARDAT_OFF) ? ard_q : 32'h0000_0000;
  wire rd_hit = (s_araddr <= ARDAT_OFF) & (s_araddr[1:0] == 2'b00)
                & (s_araddr != ACMD_OFF);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_q    <= 1'b0;
      r_q     <= 1'b0;
      rdata_q <= RST_ZERO;
      rresp_q <= RESP_OK;
    end else if (ce) begin
      ar_q <= s_arvalid & ~ar_q & ~r_q;
      if (rd_go) begin
        r_q     <= 1'b1;
        rdata_q <= rd_hit ? rmux : 32'h0000_0000;
        rresp_q <= rd_hit ? RESP_OK : RESP_ERR;
      end else if (s_rready) begin
        r_q <= 1'b0;
      end
    end
  end
  assign s_awready = aw_q;
  assign s_wready  = aw_q;
  assign s_bvalid  = b_q;
  assign s_bresp   = bresp_q;
  assign s_arready = ar_q;
  assign s_rvalid  = r_q;
  assign s_rdata   = rdata_q;
  assign s_rresp   = rresp_q;

  // ===========================================================
  // checks
  property p_bs_pulse;
    @(posedge aclk) disable iff (!aresetn)
      (ce && $fell(bus_cycle_start_strobe_n)) |=> ce |-> !bus_cycle_start_strobe_n
        ##1 bus_cycle_start_strobe_n;
  endproperty
  a_bs_pulse: assert property (p_bs_pulse) else $error("start strobe width");
  property p_idle_dir;
    @(posedge aclk) disable iff (!aresetn) (st_q == ST_IDLE && ph_q) |-> rd_wr;
  endproperty
  a_idle_dir: assert property (p_idle_dir) else $error("direction low in idle");
  property p_match_clr;
    @(posedge aclk) disable iff (!aresetn)
      (ce && match && !wr_cnt) |=> (cnt_q == 8'h00) && cmf_q;
  endproperty
  a_match_clr: assert property (p_match_clr) else $error("match did not clear");
  property p_wrap;
    @(posedge aclk) disable iff (!aresetn)
      (ce && inc && cnt_q == 8'hff && cor_q != 8'hff && !wr_cnt) |=> cnt_q == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap");
  property p_key;
    @(posedge aclk) disable iff (!aresetn)
      (ce && wr_cor && !key_ok) |=> $stable(cor_q);
  endproperty
  a_key: assert property (p_key) else $error("unkeyed write applied");
  property p_req;
    @(posedge aclk) disable iff (!aresetn)
      (ce && match && rfen_q) |=> refresh_req && rrem_q == burst_n;
  endproperty
  a_req: assert property (p_req) else $error("refresh request missing");
  property p_two_cyc;
    @(posedge aclk) disable iff (!aresetn)
      (ce && tick && st_q == ST_T1 && wcnt_q == 4'd0 && !wseen_q)
        |=> st_q == ST_T2;
  endproperty
  a_two_cyc: assert property (p_two_cyc) else $error("no-wait access too long");
  property p_tnop;
    @(posedge aclk) disable iff (!aresetn)
      (ce && tick && st_q == ST_T2 && !last && !wm) |=> st_q == ST_TNOP;
  endproperty
  a_tnop: assert property (p_tnop) else $error("idle check cycle missing");
  property p_wait_hold;
    @(posedge aclk) disable iff (!aresetn)
      (st_q == ST_TW) |-> !cs_n && $stable(ext_addr);
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("wait cycle dropped strobe");
endmodule : ext_bus_ctrl
`default_nettype wire

// ### testbench/sram_model.sv
`default_nettype none
module sram_model (
  input  wire logic        aclk,
  input  wire logic [25:0] ext_addr,
  input  wire logic [15:0] ext_dout,
  output logic      [15:0] ext_din,
  input  wire logic        cs_n,
  input  wire logic        rd_n,
  input  wire logic [1:0]  byte_write_strobe_n,
  input  wire logic        bus_cycle_start_strobe_n,
  output logic             wait_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // beat log: {strobes, addr[15:0], data} and start cycle
  logic [33:0] bt [$];
  int          at [$];
  int          cyc    = 0;
  int          bs_len = 0;
  int          cs_end = 0;
  int          stall  = 0;
  int          low_n  = 0;
  int          cs_cnt = 0;
  logic        bs_q   = 1'b1;
  logic        cs_q   = 1'b1;
  logic [15:0] last   = 16'h0000;
  logic [15:0] mem [64];
  initial for (int i = 0; i < 64; i++) mem[i] = 16'hc000 | 16'(i);
  // buffer follows the read strobe; released bus shows inverse of last value
  assign ext_din = !rd_n ? mem[ext_addr[6:1]] : ~last;
  // wait level changes only on aclk edges, settled before the mid-cycle sample
  assign wait_n = !(cs_cnt < stall);
  always @(posedge aclk) begin
    cyc    <= cyc + 1;
    bs_q   <= bus_cycle_start_strobe_n;
    cs_q   <= cs_n;
    cs_cnt <= cs_n ? 0 : cs_cnt + 1;
    if (!rd_n) last <= ext_din;
    if (bs_q && !bus_cycle_start_strobe_n) begin
      bt.push_back({byte_write_strobe_n, ext_addr[15:0], ext_dout});
      at.push_back(cyc);
      low_n <= 1;
    end else if (!bus_cycle_start_strobe_n) low_n <= low_n + 1;
    else if (!bs_q) bs_len <= low_n;
    if (!cs_q && cs_n) cs_end <= cyc;
  end
endmodule : sram_model
`default_nettype wire

// ### testbench/tb_ext_bus_ctrl.sv
`default_nettype none
module tb_ext_bus_ctrl
  import ext_bus_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        ce = 1'b1;
  logic        endian_select_pin = 1'b0;
  logic        refresh_done = 1'b0;
  logic [7:0]  s_awaddr = 8'h00;
  logic [7:0]  s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0;
  logic [3:0]  s_wstrb = 4'hf;
  logic        s_awvalid = 1'b0;
  logic        s_wvalid = 1'b0;
  logic        s_arvalid = 1'b0;
  logic        s_bready = 1'b1;
  logic        s_rready = 1'b1;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0]  s_bresp, s_rresp, byte_write_strobe_n;
  logic [31:0] s_rdata;
  logic        wait_n, refresh_req, bus_clock_output, ext_doe_n;
  logic        cs_n, rd_n, rd_wr, bus_cycle_start_strobe_n;
  logic [25:0] ext_addr;
  logic [15:0] ext_dout, ext_din;
  int          mismatches = 0;
  int          cmp_count = 0;

  ext_bus_ctrl DUT (
    .aclk, .aresetn, .ce, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
    .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
    .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .endian_select_pin, .wait_n,
    .refresh_done, .refresh_req, .bus_clock_output, .ext_addr, .ext_dout, .ext_din,
    .ext_doe_n, .cs_n, .rd_n, .rd_wr, .byte_write_strobe_n, .bus_cycle_start_strobe_n
  );
  sram_model mdl (
    .aclk, .ext_addr, .ext_dout, .ext_din, .cs_n, .rd_n, .byte_write_strobe_n,
    .bus_cycle_start_strobe_n, .wait_n
  );

  initial forever #5 aclk = ~aclk;
  // ==========================================================
  // bus tasks
  task automatic chk(input string nm, input logic [33:0] exp, input logic [33:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic hold(ref logic s, input string nm);
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (s !== 1'b1 && n < 600);
    if (n >= 600) chk(nm, 34'h1, {33'h0, s});
  endtask : hold
  task automatic rst();
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask : rst
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_awaddr  <= a;
    s_wdata   <= d;
    s_awvalid <= 1'b1;
    s_wvalid  <= 1'b1;
    hold(s_awready, "awready");
    s_awvalid <= 1'b0;
    s_wvalid  <= 1'b0;
    hold(s_bvalid, "bvalid");
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_araddr  <= a;
    s_arvalid <= 1'b1;
    hold(s_arready, "arready");
    s_arvalid <= 1'b0;
    hold(s_rvalid, "rvalid");
    d = s_rdata;
    r = s_rresp;
  endtask : rd
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(nm, exp, d);
  endtask : rchk
  // command then poll until neither busy nor pending
  task automatic ext(input logic [7:0] a, input logic [31:0] d, input logic [31:0] c);
    logic [31:0] s;
    logic [1:0]  r;
    int          n;
    mdl.bt.delete();
    mdl.at.delete();
    wr(AADR_OFF, {24'h0, a});
    wr(AWDAT_OFF, d);
    wr(ACMD_OFF, c);
    n = 0;
    do begin
      rd(ASTAT_OFF, s, r);
      n++;
    end while (s[1:0] !== 2'b00 && n < 40);
    chk("ext idle", 34'h0, {32'h0, s[1:0]});
  endtask : ext
  task automatic beat(input int i, input logic [15:0] ad, input logic [15:0] dt,
                      input logic [1:0] sb);
    chk("beat", {sb, ad, dt}, mdl.bt[i]);
  endtask : beat
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  initial begin
    repeat (40000) @(posedge aclk);
    mismatches++;
    summarize();
  end
  // ==========================================================
  // tests
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int          ncnt [6];
    ncnt = '{1, 2, 4, 6, 8, 2};
    rst();
    rchk(RCNT_OFF, 32'h0, "count");
    rchk(RCOR_OFF, 32'h0, "constant");
    rchk(RTCS_OFF, 32'h0, "ctrl");
    rd(8'h3c, d, r);
    chk("unmapped", RESP_ERR, r);
    wr(RCOR_OFF, 32'h0000_0020);
    rchk(RCOR_OFF, 32'h0, "unkeyed");
    wr(RCOR_OFF, 32'ha55a_0020);
    rchk(RCOR_OFF, 32'h20, "keyed");
    wr(RCNT_OFF, 32'ha55a_00fe);
    rchk(RCNT_OFF, 32'hfe, "count write");
    // counter must pass 255 and wrap before it can reach the constant
    wr(RTCS_OFF, 32'ha55a_0008);
    repeat (700) @(posedge aclk);
    chk("req gated", 34'h0, refresh_req);
    rchk(RTCS_OFF, 32'h88, "flag set");
    wr(SDC_OFF, 32'h0000_0800);
    for (int i = 0; i < 6; i++) begin
      wr(RTCS_OFF, 32'ha55a_0008 | 32'(i == 5 ? 1 : i));
      hold(refresh_req, "req");
      if (i == 5) begin
        repeat (300) @(posedge aclk);
        // done pulses while frozen must not count
        ce           <= 1'b0;
        refresh_done <= 1'b1;
        repeat (3) @(posedge aclk);
        ce           <= 1'b1;
        refresh_done <= 1'b0;
        @(posedge aclk);
        chk("frozen", 34'h1, refresh_req);
      end
      for (int k = 1; k <= ncnt[i]; k++) begin
        refresh_done <= 1'b1;
        @(posedge aclk);
        refresh_done <= 1'b0;
        repeat (2) @(posedge aclk);
        chk("req level", 34'(k < ncnt[i]), refresh_req);
      end
    end
    rd(RTCS_OFF, d, r);
    wr(RTCS_OFF, 32'ha55a_0000);
    rchk(RTCS_OFF, 32'h0, "flag clear");
    $display("test refresh done");
    wr(AWC_OFF, 32'h0000_0500);
    ext(8'h10, 32'h1122_3344, 32'h6);
    beat(0, 16'h0010, 16'h1122, 2'b00);
    beat(1, 16'h0012, 16'h3344, 2'b00);
    chk("beat gap", 34'd4, mdl.at[1] - mdl.at[0]);
    chk("start len", 34'd2, mdl.bs_len);
    chk("idle dir", 34'h1, rd_wr);
    chk("idle pins", 34'h7, {ext_doe_n, rd_n, cs_n});
    ext(8'h11, 32'h0000_00ab, 32'h4);
    chk("odd lane", 8'hab, mdl.bt[0][7:0]);
    chk("odd strobe", 2'b10, mdl.bt[0][33:32]);
    ext(8'h10, 32'h0000_00cd, 32'h4);
    chk("even lane", 8'hcd, mdl.bt[0][15:8]);
    chk("even strobe", 2'b01, mdl.bt[0][33:32]);
    wr(AWC_OFF, 32'h0000_0400);
    ext(8'h20, 32'h0, 32'h2);
    chk("gap check", 34'd6, mdl.at[1] - mdl.at[0]);
    rchk(ARDAT_OFF, 32'hc010_c011, "long read");
    $display("test big 16 done");
    wr(AWC_OFF, 32'h0000_0731);
    ext(8'h40, 32'h0, 32'h4);
    chk("write waits", 34'd10, mdl.cs_end - mdl.at[0]);
    ext(8'h40, 32'h0, 32'h0);
    chk("read waits", 34'd6, mdl.cs_end - mdl.at[0]);
    wr(AWC_OFF, 32'h0000_0400);
    mdl.stall = 2;
    ext(8'h40, 32'h0, 32'h0);
    chk("ext wait", 34'd6, mdl.cs_end - mdl.at[0]);
    mdl.stall = 0;
    $display("test waits done");
    wr(AWC_OFF, 32'h0000_0100);
    ext(8'h30, 32'h1122_3344, 32'h6);
    for (int i = 0; i < 4; i++) begin
      chk("narrow addr", 34'(8'h30 + i), mdl.bt[i][31:16]);
      chk("narrow data", 34'(8'h11 * (i + 1)), mdl.bt[i][7:0]);
      chk("narrow strobe", 2'b10, mdl.bt[i][33:32]);
    end
    $display("test narrow done");
    endian_select_pin <= 1'b1;
    rst();
    rchk(ASTAT_OFF, 32'h4, "little");
    wr(AWC_OFF, 32'h0000_0500);
    ext(8'h10, 32'h1122_3344, 32'h6);
    beat(0, 16'h0010, 16'h3344, 2'b00);
    beat(1, 16'h0012, 16'h1122, 2'b00);
    ext(8'h20, 32'h0, 32'h2);
    rchk(ARDAT_OFF, 32'hc011_c010, "little read");
    $display("test little done");
    summarize();
  end
endmodule : tb_ext_bus_ctrl
`default_nettype wire
